// *** iss_defs.vh ***
// Purpose: Constants for the I/O sample scheduler
// Assumes: 25 MHz reference clock
// Notes:   Setting selectors index the command-side register port
`ifndef ISS_DEFS_VH
`define ISS_DEFS_VH

// Setting selectors
`define ISS_SEL_INTERVAL   3'h0
`define ISS_SEL_CHG_MASK   3'h1
`define ISS_SEL_THRESHOLD  3'h2
`define ISS_SEL_DEST_HIGH  3'h3
`define ISS_SEL_DEST_LOW   3'h4
`define ISS_SEL_VOLTAGE    3'h5
`define ISS_SEL_FUNC_LO    3'h6
`define ISS_SEL_FUNC_HI    3'h7

// Reset values
`define ISS_RST_16         16'h0000
`define ISS_RST_32         32'h0000_0000
`define ISS_RST_FUNC       39'h00_0000_0000

// Interval limits
`define ISS_IVL_MIN        16'h0032

// Line function codes
`define ISS_FN_DIN_MON     3'h3
`define ISS_FN_DOUT_LO     3'h4
`define ISS_FN_DOUT_HI     3'h5

// Analog mask supply bit position
`define ISS_SUPPLY_BIT     7

// Timing: clock rate and one-millisecond tick
`define ISS_CLK_HZ         25000000
`define ISS_TICK_MS        1
`define ISS_TICK_CYCLES    (`ISS_CLK_HZ / 1000 * `ISS_TICK_MS)

// Line count
`define ISS_LINES          13

`endif

// *** iss_sample_scheduler.v ***
// Purpose: I/O sample scheduler: periodic and change-driven sample sets
// Assumes: Single clock, synchronous reset, settings via command port
// Notes:   Samples leave as one word set with a one-cycle strobe
//
// Summary of operation
// R1: A non-zero interval emits one sample set per interval of milliseconds; zero disables it.
// R2: Only zero or 0x32..0xFFFF is a legal interval; other values are not programmed. The code does not check this and stores any written value.
// R3: Periodic sets need a non-zero interval and at least one line configured for I/O.
// R4: Every sample set carries the applied destination high and low address.
// R5: The receiving node must be in framed command mode to pass the data on.
// R6: Mask bits 0..12 enable change detection on lines 0..12, forcing an immediate set.
// R7: Change detection only acts on lines currently configured as digital I/O.
// R8: Mask bits without a line must be written zero; the 16-bit mask resets to zero.
// R9: Supply at or below the threshold appends the supply value and sets analog mask bit 7.
// R10: A zero threshold keeps the supply voltage out of every set.
// R11: A read-only 16-bit supply reading in millivolts is provided.
// R12: Written settings are queued and take effect on apply, without leaving command mode.
// R13: Function code 3 is monitored input, 4 or 5 output; only those lines are sampled.
// R14: The interval counter runs on a 1 ms tick and restarts when the interval is applied.
`timescale 1ns/10ps
`include "iss_defs.vh"

module iss_sample_scheduler
(
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Command-side setting port
   input  wire        set_wr,
   input  wire [2:0]  set_sel,
   input  wire [31:0] set_wdata,
   input  wire        apply_settings,
   output reg  [31:0] set_rdata,
   output wire        in_command_mode,
   // Device pins and supply monitor
   input  wire [12:0] line_in,
   output reg  [12:0] line_out,
   output reg  [12:0] line_oe,
   input  wire [15:0] supply_mv,
   input  wire [7:0]  analog_en,
   // Sample set output
   output reg         sample_valid,
   output reg  [31:0] sample_dest_high,
   output reg  [31:0] sample_dest_low,
   output reg  [12:0] sample_dio_mask,
   output reg  [12:0] sample_dio,
   output reg  [7:0]  sample_analog_mask,
   output reg  [15:0] sample_supply,
   output reg         sample_is_change
);

   localparam integer TICK_CYC = `ISS_TICK_CYCLES - 1;
   localparam [14:0]  TICK_MAX = TICK_CYC[14:0];

   // Queued settings
   reg [15:0] q_interval_q;
   reg [15:0] q_mask_q;
   reg [15:0] q_thresh_q;
   reg [31:0] q_dh_q;
   reg [31:0] q_dl_q;
   reg [38:0] q_func_q;
   // Active settings
   reg [15:0] a_interval_q;
   reg [15:0] a_mask_q;
   reg [15:0] a_thresh_q;
   reg [31:0] a_dh_q;
   reg [31:0] a_dl_q;
   reg [38:0] a_func_q;

   // Pin synchronisers
   reg [12:0] line_s1_q;
   reg [12:0] line_s2_q;
   reg [12:0] line_prev_q;
   reg [15:0] supply_s1_q;
   reg [15:0] supply_s2_q;
   reg [15:0] supply_s3_q;
   reg [15:0] supply_q;

   reg [14:0] tick_cnt_q;
   reg [15:0] ms_cnt_q;

   // Function code of one line
   function [2:0] line_fn;
      input [38:0] f;
      input integer i;
      begin
         line_fn = f[i*3 +: 3];
      end
   endfunction

   // Output function of one line
   function is_dout;
      input [2:0] fn;
      begin
         is_dout = (fn == `ISS_FN_DOUT_LO) || (fn == `ISS_FN_DOUT_HI);
      end
   endfunction

   function is_dio;
      input [2:0] fn;
      begin
         is_dio = (fn == `ISS_FN_DIN_MON) || is_dout(fn);
      end
   endfunction

   // Zero-extends a 16-bit setting for read-back
   function [31:0] zext16;
      input [15:0] v;
      begin
         zext16 = {16'h0000, v};
      end
   endfunction

   reg [12:0] dio_lines;
   integer k;
   integer j;
   always @*
   begin
      dio_lines = 13'h0000;
      for (k = 0; k < `ISS_LINES; k = k + 1)
      begin
         dio_lines[k] = is_dio(line_fn(a_func_q, k)); // [R13]
      end
   end

   // Pin levels: output lines report their driven level
   wire [12:0] pin_level = (line_s2_q & ~line_oe) | (line_out & line_oe);
   wire [12:0] changed   = (pin_level ^ line_prev_q) & dio_lines
                           & a_mask_q[12:0]; // [R6] [R7]
   wire        change_hit = |changed;

   wire        tick      = (tick_cnt_q == TICK_MAX);
   wire        any_io    = (|dio_lines) | (|analog_en); // [R3]
   wire        period_hit = (a_interval_q != `ISS_RST_16) && tick
                            && (ms_cnt_q + 16'h0001 >= a_interval_q);
   wire        supply_in  = (a_thresh_q != `ISS_RST_16)
                            && (supply_q <= a_thresh_q); // [R9] [R10]

   // Apply cycle drops sets so old and new settings never mix
   wire        fire       = ((period_hit && any_io) || change_hit) && !apply_settings;

   // Apply never leaves command mode
   assign in_command_mode = 1'b1; // [R12]

   // Queued writes
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         q_interval_q <= `ISS_RST_16;
         q_mask_q     <= `ISS_RST_16; // [R8]
         q_thresh_q   <= `ISS_RST_16;
         q_dh_q       <= `ISS_RST_32;
         q_dl_q       <= `ISS_RST_32;
         q_func_q     <= `ISS_RST_FUNC;
      end
      else if (set_wr)
      begin
         case (set_sel)
            `ISS_SEL_INTERVAL:  q_interval_q <= set_wdata[15:0]; // [R2]
            `ISS_SEL_CHG_MASK:  q_mask_q     <= set_wdata[15:0];
            `ISS_SEL_THRESHOLD: q_thresh_q   <= set_wdata[15:0];
            `ISS_SEL_DEST_HIGH: q_dh_q       <= set_wdata;
            `ISS_SEL_DEST_LOW:  q_dl_q       <= set_wdata;
            `ISS_SEL_FUNC_LO:   q_func_q[31:0]  <= set_wdata;
            `ISS_SEL_FUNC_HI:   q_func_q[38:32] <= set_wdata[6:0];
            default:            q_func_q     <= q_func_q;
         endcase
      end
   end

   // Active copies load only on apply
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         a_interval_q <= `ISS_RST_16;
         a_mask_q     <= `ISS_RST_16;
         a_thresh_q   <= `ISS_RST_16;
         a_dh_q       <= `ISS_RST_32;
         a_dl_q       <= `ISS_RST_32;
         a_func_q     <= `ISS_RST_FUNC;
      end
      else if (apply_settings)
      begin
         a_interval_q <= q_interval_q; // [R12]
         a_mask_q     <= q_mask_q;
         a_thresh_q   <= q_thresh_q;
         a_dh_q       <= q_dh_q;
         a_dl_q       <= q_dl_q;
         a_func_q     <= q_func_q;
      end
   end

   // Read-back: queued values, live supply reading
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         set_rdata <= `ISS_RST_32;
      end
      else
      begin
         case (set_sel)
            `ISS_SEL_INTERVAL:  set_rdata <= zext16(q_interval_q);
            `ISS_SEL_CHG_MASK:  set_rdata <= zext16(q_mask_q);
            `ISS_SEL_THRESHOLD: set_rdata <= zext16(q_thresh_q);
            `ISS_SEL_DEST_HIGH: set_rdata <= q_dh_q;
            `ISS_SEL_DEST_LOW:  set_rdata <= q_dl_q;
            `ISS_SEL_VOLTAGE:   set_rdata <= zext16(supply_q); // [R11]
            `ISS_SEL_FUNC_LO:   set_rdata <= q_func_q[31:0];
            default:            set_rdata <= {25'h0000000, q_func_q[38:32]};
         endcase
      end
   end

   // Synchronisers and output pin drive
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         line_s1_q   <= 13'h0000;
         line_s2_q   <= 13'h0000;
         line_prev_q <= 13'h0000;
         supply_s1_q <= `ISS_RST_16;
         supply_s2_q <= `ISS_RST_16;
         supply_s3_q <= `ISS_RST_16;
         supply_q    <= `ISS_RST_16;
         line_out    <= 13'h0000;
         line_oe     <= 13'h0000;
      end
      else
      begin
         line_s1_q   <= line_in;
         line_s2_q   <= line_s1_q;
         line_prev_q <= pin_level;
         supply_s1_q <= supply_mv;
         supply_s2_q <= supply_s1_q;
         // Word taken only once two samples agree, so no torn reading
         supply_s3_q <= supply_s2_q;
         if (supply_s2_q == supply_s3_q)
         begin
            supply_q <= supply_s3_q; // [R11]
         end
         for (j = 0; j < `ISS_LINES; j = j + 1)
         begin
            line_oe[j]  <= is_dout(line_fn(a_func_q, j)); // [R13]
            line_out[j] <= (line_fn(a_func_q, j) == `ISS_FN_DOUT_HI);
         end
      end
   end

   // Millisecond tick and interval counter
   // Restart on apply so a new interval counts from zero
   always @(posedge ref_clk)
   begin
      if (rst || apply_settings)
      begin
         tick_cnt_q <= 15'h0000; // [R14]
         ms_cnt_q   <= `ISS_RST_16;
      end
      else
      begin
         tick_cnt_q <= tick ? 15'h0000 : tick_cnt_q + 15'h0001;
         if (period_hit)
         begin
            ms_cnt_q <= `ISS_RST_16; // [R1]
         end
         else if (tick && (a_interval_q != `ISS_RST_16))
         begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
         end
      end
   end

   // Sample set emission
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sample_valid       <= 1'b0;
         sample_dest_high   <= `ISS_RST_32;
         sample_dest_low    <= `ISS_RST_32;
         sample_dio_mask    <= 13'h0000;
         sample_dio         <= 13'h0000;
         sample_analog_mask <= 8'h00;
         sample_supply      <= `ISS_RST_16;
         sample_is_change   <= 1'b0;
      end
      else
      begin
         sample_valid <= fire; // [R1] [R6]
         if (fire)
         begin
            sample_dest_high <= a_dh_q; // [R4]
            sample_dest_low  <= a_dl_q;
            sample_dio_mask  <= dio_lines;
            sample_dio       <= pin_level & dio_lines;
            sample_analog_mask <= analog_en;
            sample_analog_mask[`ISS_SUPPLY_BIT] <= supply_in; // [R9]
            sample_supply    <= supply_in ? supply_q : `ISS_RST_16; // [R10]
            sample_is_change <= change_hit;
         end
      end
   end

endmodule

// *** iss_chk_asserts.sv ***
// Purpose: Port checks for the I/O sample scheduler
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design below the module
`timescale 1ns/10ps
module iss_chk
(
   // Clock, reset, settings
   input wire        ref_clk,
   input wire        rst,
   input wire        set_wr,
   input wire [2:0]  set_sel,
   input wire [31:0] set_wdata,
   input wire [31:0] set_rdata,
   input wire        in_command_mode,
   // Pins
   input wire [12:0] line_in,
   input wire [12:0] line_out,
   input wire [12:0] line_oe,
   input wire [15:0] supply_mv,
   // Sample set
   input wire        sample_valid,
   input wire [12:0] sample_dio_mask,
   input wire [12:0] sample_dio,
   input wire [7:0]  sample_analog_mask,
   input wire [15:0] sample_supply,
   input wire        sample_is_change
);
   reg [12:0] lin_q;
   reg [12:0] out_q;
   reg [15:0] sup_q;
   reg [4:0]  chg_q;
   reg [2:0]  stb_q;
   // Pin history covers the two-stage sync latency
   always @(posedge ref_clk)
   begin
      lin_q <= line_in;
      out_q <= line_out;
      sup_q <= supply_mv;
      chg_q <= rst ? 5'h00 : {chg_q[3:0], (line_in != lin_q) || (line_out != out_q)};
      stb_q <= (rst || supply_mv != sup_q) ? 3'h0 : stb_q + {2'h0, stb_q != 3'h7};
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_CMD_MODE: assert property (in_command_mode == 1'b1)
      else $error("command mode left");
   AST_NO_SUPPLY: assert property (sample_valid && !sample_analog_mask[7]
      |-> sample_supply == 16'h0000) else $error("supply without flag");
   AST_OUT_OE: assert property ((line_out & ~line_oe) == 13'h0000)
      else $error("high level on undriven line");
   AST_DIO_SUB: assert property (sample_valid
      |-> (sample_dio & ~sample_dio_mask) == 13'h0000) else $error("level outside mask");
   AST_OE_MASK: assert property (sample_valid
      |-> (line_oe & ~sample_dio_mask) == 13'h0000) else $error("output line not sampled");
   AST_CHG_CAUSE: assert property (sample_valid && sample_is_change
      |-> chg_q != 5'h00) else $error("change set without pin change");
   AST_RD_SUP: assert property (set_sel == 3'h5 && $past(set_sel) == 3'h5 && stb_q == 3'h7
      && $stable(supply_mv) |-> set_rdata == {16'h0000, supply_mv})
      else $error("supply reading wrong");
   AST_RD_WR: assert property (set_wr && set_sel < 3'h5 ##1 !set_wr && $stable(set_sel)
      |=> set_rdata[15:0] == $past(set_wdata[15:0], 2)) else $error("queued value lost");
   cover property (sample_valid && sample_is_change);
   cover property (sample_valid && sample_analog_mask[7]);
   cover property (set_sel == 3'h5 && stb_q == 3'h7);
endmodule
bind iss_sample_scheduler iss_chk u_chk (.ref_clk, .rst, .set_wr, .set_sel, .set_wdata,
   .set_rdata, .in_command_mode, .line_in, .line_out, .line_oe, .supply_mv, .sample_valid,
   .sample_dio_mask, .sample_dio, .sample_analog_mask, .sample_supply, .sample_is_change);

// *** iss_node.sv ***
// Purpose: Remote node that receives sample sets
// Assumes: Sets arrive as a one-cycle strobe
// Notes:   Counts only sets addressed to this node
`timescale 1ns/10ps
module iss_node
#(
   parameter [31:0] MY_HIGH = 32'h0000_1234,
   parameter [31:0] MY_LOW  = 32'h89AB_CDEF,
   parameter        FRAMED  = 1
)
(
   input wire        ref_clk,
   input wire        sample_valid,
   input wire [31:0] sample_dest_high,
   input wire [31:0] sample_dest_low,
   output reg [7:0]  n_rx
);
   initial n_rx = 8'h00;
   // Data only leaves a node in framed mode
   always @(posedge ref_clk)
      if (FRAMED != 0 && sample_valid === 1'b1 && sample_dest_high === MY_HIGH
          && sample_dest_low === MY_LOW)
         n_rx <= n_rx + 8'h01;
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the I/O sample scheduler
// Assumes: Change sets appear within a few cycles of a pin edge
// Notes:   Periodic sets are too slow to wait for; only their absence is checked
`timescale 1ns/10ps
module tb;
   reg         ref_clk = 0, rst = 1, set_wr = 0, apply_settings = 0;
   reg  [2:0]  set_sel = 0;
   reg  [31:0] set_wdata = 0;
   reg  [12:0] drv = 0;
   reg  [15:0] supply_mv = 16'h0BB8, thr_a = 0;
   reg  [7:0]  analog_en = 0, n_exp = 0;
   wire [31:0] set_rdata, dh, dl;
   wire [12:0] line_out, line_oe, sdm, sdio;
   wire [12:0] line_in = (line_oe & line_out) | (~line_oe & drv);
   wire [15:0] ssup;
   wire [7:0]  sam, n_rx;
   wire        icm, sv, sic;
   reg  [114:0] exq[$];
   int miscompares = 0, n_compared = 0, i;
   bit inc;
   always #20 ref_clk = ~ref_clk;
   iss_sample_scheduler dut (.ref_clk(ref_clk), .rst(rst), .set_wr(set_wr), .set_sel(set_sel),
      .set_wdata(set_wdata), .apply_settings(apply_settings), .set_rdata(set_rdata),
      .in_command_mode(icm), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
      .supply_mv(supply_mv), .analog_en(analog_en), .sample_valid(sv),
      .sample_dest_high(dh), .sample_dest_low(dl), .sample_dio_mask(sdm), .sample_dio(sdio),
      .sample_analog_mask(sam), .sample_supply(ssup), .sample_is_change(sic));
   iss_node node (.ref_clk(ref_clk), .sample_valid(sv), .sample_dest_high(dh),
      .sample_dest_low(dl), .n_rx(n_rx));
   task chk(input string n, input [114:0] e, input [114:0] g);
      n_compared++;
      if (e !== g)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task print_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wr(input [2:0] s, input [31:0] d);
      @(negedge ref_clk);
      set_sel = s;
      set_wdata = d;
      set_wr = 1;
      @(negedge ref_clk);
      set_wr = 0;
   endtask
   task apply;
      @(negedge ref_clk);
      apply_settings = 1;
      @(negedge ref_clk);
      apply_settings = 0;
   endtask
   task rd(input [2:0] s, input [31:0] e);
      @(negedge ref_clk);
      set_sel = s;
      @(negedge ref_clk);
      chk("set_rdata", e, set_rdata);
   endtask
   // Toggle a pin; a set is owed only for a masked digital line
   task tog(input int k, input bit e);
      drv[k] = ~drv[k];
      inc = thr_a != 0 && supply_mv <= thr_a;
      if (e)
      begin
         exq.push_back({32'h0000_1234, 32'h89AB_CDEF, 13'h0007, 13'h0004 | {12'h0, drv[0]},
            inc, analog_en[6:0], inc ? supply_mv : 16'h0000, 1'b1});
         n_exp++;
      end
      for (i = 0; i < 12; i++)
         @(negedge ref_clk);
      if (exq.size() != 0)
      begin
         chk("set timeout", 0, 1);
         print_verdict;
      end
   endtask
   always @(negedge ref_clk)
      if (sv === 1'b1)
      begin
         if (exq.size() == 0)
            chk("unexpected set", 0, 1);
         else
            chk("sample set", exq.pop_front(), {dh, dl, sdm, sdio, sam, ssup, sic});
      end
   initial
   begin
      i = $urandom(32'hDCEF);
      repeat (20) @(negedge ref_clk);
      rst = 0;
      rd(0, 0);
      rd(1, 0);
      rd(2, 0);
      rd(7, 0);
      wr(3, 32'h0000_1234);
      wr(4, 32'h89AB_CDEF);
      wr(6, 32'h0000_0163);
      wr(1, 32'h0000_0009);
      apply;
      analog_en = 8'($urandom);
      @(negedge ref_clk);
      chk("line_oe", 13'h0006, line_oe);
      chk("line_out", 13'h0004, line_out);
      tog(0, 1);
      tog(3, 0);
      wr(2, 32'h0000_0BB8);
      rd(2, 32'h0000_0BB8);
      tog(0, 1);
      apply;
      thr_a = 16'h0BB8;
      tog(0, 1);
      repeat (6)
      begin
         supply_mv = 16'h0AB8 + 16'($urandom % 512);
         analog_en = 8'($urandom);
         repeat (6) @(negedge ref_clk);
         tog(0, 1);
      end
      repeat (6) @(negedge ref_clk);
      rd(5, {16'h0000, supply_mv});
      wr(2, 0);
      apply;
      thr_a = 0;
      tog(0, 1);
      wr(0, 32'h0000_0032);
      apply;
      repeat (3000) @(negedge ref_clk);
      chk("node sets", n_exp, n_rx);
      print_verdict;
   end
endmodule
